// [isr_pkg.sv]
package isr_pkg;
  localparam int unsigned UPLOAD_BITS = 16;
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned DATA_BITS = 12;
  // register addresses (4-bit field of the upload word)
  localparam logic [3:0] ADDR_HWIN = 4'h0;
  localparam logic [3:0] ADDR_VWIN = 4'h1;
  localparam logic [3:0] ADDR_CORE = 4'h2;
  localparam logic [3:0] ADDR_AMP = 4'h3;
  localparam logic [3:0] ADDR_BLC = 4'h4;
  localparam logic [3:0] ADDR_BLF = 4'h5;
  localparam logic [3:0] ADDR_CAL = 4'h6;
  localparam logic [3:0] ADDR_CONV = 4'h7;
  localparam logic [3:0] ADDR_PIXCNT = 4'h8;
  localparam logic [3:0] ADDR_LINECNT = 4'h9;
  localparam logic [3:0] ADDR_STRDLY = 4'hA;
  // window limits
  localparam logic [11:0] HWIN_POSITIONS = 12'h063;
  localparam logic [11:0] VWIN_POSITIONS = 12'h08A;
  localparam int unsigned WIN_STEP_PIX = 24;
  // reset values
  localparam logic [11:0] RST_ZERO = 12'h000;
  localparam logic [11:0] RST_BLF = 12'h080;
  // amplifier register fields
  localparam int unsigned AMP_GAIN_LSB = 0;
  localparam int unsigned AMP_BYPASS = 4;
  localparam int unsigned AMP_SINGLE = 5;
  localparam int unsigned AMP_STBY = 6;
  localparam int unsigned AMP_CKDLY_LSB = 7;
  // converter register fields
  localparam int unsigned CONV_STBY1 = 0;
  localparam int unsigned CONV_STBY2 = 1;
  localparam int unsigned CONV_SINGLE = 2;
  localparam int unsigned CONV_SWITCH = 3;
  localparam int unsigned CONV_EXTCLK = 4;
  localparam int unsigned CONV_FLOAT = 5;
  localparam int unsigned CONV_CKDLY_LSB = 6;
  localparam int unsigned CONV_GAMMA = 9;
  localparam int unsigned CONV_INVERT = 10;
  // timing
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned SERIAL_MAX_MHZ = 20;
  localparam int unsigned FSTART_MIN_CYC = 3;
  localparam int unsigned ANALOG_LAT_DUAL = 4;
  localparam int unsigned ANALOG_LAT_SINGLE = 5;
  localparam int unsigned CONV_PIPE = 2;
  localparam int unsigned DLY_MAX = 13;
  localparam int unsigned DLY_OFFSET = 2;
  localparam int unsigned PIX_W = 10;
  typedef enum logic [1:0] {ISR_IDLE, ISR_READ, ISR_EOL} isr_state_t;
endpackage : isr_pkg

// [isr_dline.sv]
`timescale 1ns/1ps
`default_nettype none
// variable tap delay line for a single strobe
module isr_dline
  import isr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic din,
  input wire logic [3:0] code,
  output logic dout
);
  logic [DLY_MAX:0] tap_q;
  logic [3:0] sel;

  // --------------------------------------------------------------
  // shift taps
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tap_q <= '0;
    else if (ce)
      tap_q <= {tap_q[DLY_MAX-1:0], din};
  end

  // codes 0..2 all mean no extra delay
  always_comb
  begin
    sel = (code < 4'(DLY_OFFSET)) ? 4'h0 : code - 4'(DLY_OFFSET);
    dout = (sel == 4'h0) ? din : tap_q[sel-4'h1];
  end
endmodule : isr_dline
`default_nettype wire

// [isr_readout.sv]
`timescale 1ns/1ps
`default_nettype none
// readout controller: serial upload chain, configuration and strobes
module isr_readout
  import isr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic upload_clk,
  input wire logic upload_data,
  input wire logic load_strobe,
  input wire logic row_clock,
  input wire logic frame_start,
  input wire logic [PIX_W-1:0] conv_a_code,
  input wire logic [PIX_W-1:0] conv_b_code,
  input wire logic ext_conv_clk,
  output logic pixel_valid,
  output logic end_of_line,
  output logic end_of_frame,
  output logic analog_valid,
  output logic [PIX_W-1:0] pix_out,
  output logic [PIX_W-1:0] pix_oe,
  output logic [11:0] hwin_start,
  output logic [11:0] vwin_start,
  output logic [1:0] test_mode,
  output logic [2:0] hsub_mode,
  output logic [2:0] vsub_mode,
  output logic [3:0] amp_gain,
  output logic amp_unity,
  output logic analog_video_a_mux,
  output logic amp_b_standby,
  output logic amp_standby,
  output logic [2:0] amp_clk_delay,
  output logic amp_clk_invert,
  output logic [7:0] black_coarse,
  output logic [7:0] black_fine,
  output logic [11:0] cal_level,
  output logic conv_a_standby,
  output logic conv_b_standby,
  output logic [2:0] conv_clk_delay,
  output logic conv_clk_invert,
  output logic conv_gamma,
  output logic conv_clk_ext_sel
);
  // ----------------------------------------------------------------
  // serial upload chain
  // ----------------------------------------------------------------
  logic [UPLOAD_BITS-1:0] chain_q;

  // sixteen cells, each feeding the next, msb ends up first in [15]
  always_ff @(posedge upload_clk or negedge rst_n)
  begin
    if (!rst_n)
      chain_q <= '0;
    else
      chain_q <= {chain_q[UPLOAD_BITS-2:0], upload_data};
  end

  // strobe is asynchronous to clk, so bring it over with two flops
  logic ld_s1_q, ld_s2_q, ld_s3_q, ld_rise;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ld_s1_q <= 1'b0;
      ld_s2_q <= 1'b0;
      ld_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      ld_s1_q <= load_strobe;
      ld_s2_q <= ld_s1_q;
      ld_s3_q <= ld_s2_q;
    end
  end
  assign ld_rise = ld_s2_q & ~ld_s3_q;

  // chain is quiet while the strobe is high, so reading it here is safe
  logic [ADDR_BITS-1:0] up_addr;
  logic [DATA_BITS-1:0] up_data;
  assign up_addr = chain_q[UPLOAD_BITS-1 -: ADDR_BITS];
  assign up_data = chain_q[DATA_BITS-1:0];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [11:0] hwin_q, vwin_q, core_q, amp_q, blc_q, blf_q, cal_q, conv_q;
  logic [11:0] pixcnt_q, linecnt_q, strdly_q;

  // copy on strobe rise, effective immediately
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hwin_q <= RST_ZERO;
      vwin_q <= RST_ZERO;
      core_q <= RST_ZERO;
      amp_q <= RST_ZERO;
      blc_q <= RST_ZERO;
      blf_q <= RST_BLF;
      cal_q <= RST_ZERO;
      conv_q <= RST_ZERO;
      pixcnt_q <= RST_ZERO;
      linecnt_q <= RST_ZERO;
      strdly_q <= RST_ZERO;
    end
    else if (ce && ld_rise)
    begin
      unique case (up_addr)
        ADDR_HWIN: hwin_q <= up_data;
        ADDR_VWIN: vwin_q <= up_data;
        ADDR_CORE: core_q <= up_data;
        ADDR_AMP: amp_q <= up_data;
        ADDR_BLC: blc_q <= up_data;
        ADDR_BLF: blf_q <= up_data;
        ADDR_CAL: cal_q <= up_data;
        ADDR_CONV: conv_q <= up_data;
        ADDR_PIXCNT: pixcnt_q <= up_data;
        ADDR_LINECNT: linecnt_q <= up_data;
        ADDR_STRDLY: strdly_q <= up_data;
        default: ;
      endcase
    end
  end

  // window starts clamp to the last legal position
  assign hwin_start = (hwin_q >= HWIN_POSITIONS) ?
    HWIN_POSITIONS - 12'h001 : hwin_q;
  assign vwin_start = (vwin_q >= VWIN_POSITIONS) ?
    VWIN_POSITIONS - 12'h001 : vwin_q;
  assign test_mode = core_q[1:0];
  assign hsub_mode = core_q[4:2];
  assign vsub_mode = core_q[7:5];
  // gain forced to zero code under bypass
  assign amp_unity = amp_q[AMP_BYPASS];
  assign amp_gain = amp_q[AMP_BYPASS] ? 4'h0 : amp_q[AMP_GAIN_LSB +: 4];
  assign analog_video_a_mux = amp_q[AMP_SINGLE];
  assign amp_b_standby = amp_q[AMP_SINGLE] | amp_q[AMP_STBY];
  assign amp_standby = amp_q[AMP_STBY];
  assign amp_clk_delay = amp_q[AMP_CKDLY_LSB +: 3];
  assign amp_clk_invert = amp_q[AMP_CKDLY_LSB+2];
  assign black_coarse = blc_q[7:0];
  assign black_fine = blf_q[7:0];
  assign cal_level = cal_q;
  assign conv_a_standby = conv_q[CONV_STBY1];
  assign conv_b_standby = conv_q[CONV_STBY2];
  assign conv_clk_delay = conv_q[CONV_CKDLY_LSB +: 3];
  assign conv_clk_invert = conv_q[CONV_CKDLY_LSB+2];
  assign conv_gamma = conv_q[CONV_GAMMA];
  assign conv_clk_ext_sel = conv_q[CONV_EXTCLK];

  // ----------------------------------------------------------------
  // sequencer: frame and line timing
  // ----------------------------------------------------------------
  logic rc_s1_q, rc_q, fs_s1_q, fs_q, rc_d1_q, fs_d1_q;
  // controller signals are on clk already but treated as pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc_s1_q <= 1'b0;
      rc_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_q <= 1'b0;
      rc_d1_q <= 1'b0;
      fs_d1_q <= 1'b0;
    end
    else if (ce)
    begin
      rc_s1_q <= row_clock;
      rc_q <= rc_s1_q;
      fs_s1_q <= frame_start;
      fs_q <= fs_s1_q;
      rc_d1_q <= rc_q;
      fs_d1_q <= fs_q;
    end
  end

  isr_state_t state_q;
  logic [12:0] pix_q;
  logic [11:0] line_q;
  logic row_start, last_pix, last_line, eof_raw;
  logic pv_raw, eol_raw;
  assign row_start = rc_d1_q & ~rc_q; // row clock falling
  // pairs counted, count+1 pairs per row
  assign last_pix = (pix_q == {1'b0, pixcnt_q});
  assign last_line = (line_q == linecnt_q);

  // state machine: ISR_READ suspended while row clock high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ISR_IDLE;
    else if (ce)
    begin
      unique case (state_q)
        ISR_IDLE: if (row_start || (fs_d1_q && !fs_q)) state_q <= ISR_READ;
        ISR_READ: if (rc_q) state_q <= ISR_READ;
                  else if (last_pix) state_q <= ISR_EOL;
        ISR_EOL: state_q <= ISR_IDLE;
      endcase
    end
  end

  // pixel counter held clear outside ISR_READ
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pix_q <= '0;
    else if (ce)
    begin
      if (state_q != ISR_READ)
        pix_q <= '0;
      else if (!rc_q && !last_pix)
        pix_q <= pix_q + 13'h0001;
    end
  end

  // line counter: reset on frame start, advance at each end of line until it reaches linecnt_q, then hold
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      line_q <= '0;
    else if (ce)
    begin
      if (fs_q)
        line_q <= '0;
      else if (state_q == ISR_EOL && !last_line)
        line_q <= line_q + 12'h001;
    end
  end

  assign pv_raw = (state_q == ISR_READ);
  assign eol_raw = (state_q == ISR_EOL);
  assign eof_raw = eol_raw & last_line;

  // strobe delays from the two nibbles
  logic pv_dly, eol_dly, eof_dly;
  isr_dline u_pv (.clk(clk), .rst_n(rst_n), .ce(ce), .din(pv_raw),
    .code(strdly_q[3:0]), .dout(pv_dly));
  isr_dline u_eol (.clk(clk), .rst_n(rst_n), .ce(ce), .din(eol_raw),
    .code(strdly_q[7:4]), .dout(eol_dly));
  isr_dline u_eof (.clk(clk), .rst_n(rst_n), .ce(ce), .din(eof_raw),
    .code(strdly_q[7:4]), .dout(eof_dly));

  // register strobes so outputs stay glitch free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pixel_valid <= 1'b0;
      end_of_line <= 1'b0;
      end_of_frame <= 1'b0;
    end
    else if (ce)
    begin
      pixel_valid <= pv_dly;
      end_of_line <= eol_dly;
      end_of_frame <= eof_dly;
    end
  end

  // ----------------------------------------------------------------
  // analog output validity
  // ----------------------------------------------------------------
  logic [ANALOG_LAT_SINGLE-1:0] av_q;
  // history of undelayed pixel valid, tap 4 or 5
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      av_q <= '0;
    else if (ce)
      av_q <= {av_q[ANALOG_LAT_SINGLE-2:0], pv_raw};
  end
  assign analog_valid = amp_q[AMP_SINGLE] ? av_q[ANALOG_LAT_SINGLE-1] :
    av_q[ANALOG_LAT_DUAL-1];

  // ----------------------------------------------------------------
  // converter path and digital output
  // ----------------------------------------------------------------
  // internal pixel clock at half rate
  logic pclk_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pclk_q <= 1'b0;
    else if (ce)
      pclk_q <= ~pclk_q;
  end

  // external converter clock is a pin: two flops before use
  logic ek_s1_q, ek_s2_q, ek_s3_q, conv_tick;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ek_s1_q <= 1'b0;
      ek_s2_q <= 1'b0;
      ek_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      ek_s1_q <= ext_conv_clk;
      ek_s2_q <= ek_s1_q;
      ek_s3_q <= ek_s2_q;
    end
  end
  // falling edge of the chosen converter clock samples
  assign conv_tick = conv_q[CONV_EXTCLK] ? (ek_s3_q & ~ek_s2_q) : pclk_q;

  // two-stage pipeline per converter
  logic [PIX_W-1:0] ca_p_q [CONV_PIPE];
  logic [PIX_W-1:0] cb_p_q [CONV_PIPE];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ca_p_q <= '{default: '0};
      cb_p_q <= '{default: '0};
    end
    else if (ce && conv_tick)
    begin
      ca_p_q[0] <= conv_a_code;
      ca_p_q[1] <= ca_p_q[0];
      cb_p_q[0] <= conv_b_code;
      cb_p_q[1] <= cb_p_q[0];
    end
  end

  // interleave or pick one converter; switch adds a cycle in dual mode
  logic [PIX_W-1:0] sel_w, sel_dly_q, word;
  logic phase;
  assign phase = conv_q[CONV_EXTCLK] ? ek_s2_q : pclk_q;
  always_comb
  begin
    if (conv_q[CONV_SINGLE])
      sel_w = conv_q[CONV_SWITCH] ? cb_p_q[1] : ca_p_q[1];
    else
      sel_w = phase ? cb_p_q[1] : ca_p_q[1];
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_dly_q <= '0;
    else if (ce)
      sel_dly_q <= sel_w;
  end
  // dual mode with switch set takes the one-cycle late word
  assign word = (!conv_q[CONV_SINGLE] && conv_q[CONV_SWITCH]) ?
    sel_dly_q : sel_w;

  // output register with optional inversion
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pix_out <= '0;
    else if (ce)
      pix_out <= conv_q[CONV_INVERT] ? ~word : word;
  end
  // float bit releases all ten lines
  assign pix_oe = conv_q[CONV_FLOAT] ? '0 : '1;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_eol_after_pv: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pv_raw && !$past(rc_q) && last_pix && !rc_q |=> eol_raw)
    else $error("eol did not follow last pixel");
  a_eof_on_last: assert property (@(posedge clk) disable iff (!rst_n)
    eof_raw |-> eol_raw && line_q == linecnt_q)
    else $error("eof without last line");
  a_float_lines: assert property (@(posedge clk) disable iff (!rst_n)
    conv_q[CONV_FLOAT] |-> pix_oe == '0)
    else $error("outputs driven while floating");
  a_gain_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    amp_q[AMP_BYPASS] |-> amp_gain == 4'h0 && amp_unity)
    else $error("gain used under bypass");
  a_single_mux: assert property (@(posedge clk) disable iff (!rst_n)
    amp_q[AMP_SINGLE] |-> amp_b_standby && analog_video_a_mux)
    else $error("second path not in standby");
  a_load_takes: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ld_rise && up_addr == ADDR_CONV |=> conv_q == $past(up_data))
    else $error("register not loaded on strobe");
  a_suspend_row: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rc_q && state_q == ISR_READ |=> state_q == ISR_READ)
    else $error("sequencer ran during row clock");
  a_analog_lat: assert property (@(posedge clk) disable iff (!rst_n)
    ce && $rose(pv_raw) && !amp_q[AMP_SINGLE] ##1 ce[*4] ##0
    !amp_q[AMP_SINGLE] |-> analog_valid)
    else $error("analog valid late");
  a_pix_bound: assert property (@(posedge clk) disable iff (!rst_n)
    pix_q <= {1'b0, pixcnt_q})
    else $error("pixel counter past count");
  c_row_done: cover property (@(posedge clk) disable iff (!rst_n) eol_raw);
  c_frame_done: cover property (@(posedge clk) disable iff (!rst_n) eof_raw);
  c_load: cover property (@(posedge clk) disable iff (!rst_n) ld_rise);
endmodule : isr_readout
`default_nettype wire

// [isr_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// camera controller model: upload and row/frame pulses
// ----------------------------------------
module isr_ctrl_model
(
  input wire logic clk,
  output logic upload_clk,
  output logic upload_data,
  output logic load_strobe,
  output logic row_clock,
  output logic frame_start
);
  // serial clock parked low outside words
  initial
  begin
    upload_clk = 1'b0;
    upload_data = 1'b0;
    load_strobe = 1'b0;
    row_clock = 1'b0;
    frame_start = 1'b0;
  end

  // one word: address first, both fields msb first
  task automatic upload(input logic [3:0] addr, input logic [11:0] data);
    logic [15:0] word;
    word = {addr, data};
    // half the system rate keeps the serial clock under 20 MHz
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk);
      upload_data <= word[i];
      upload_clk <= 1'b0;
      @(posedge clk);
      upload_clk <= 1'b1;
    end
    @(posedge clk);
    upload_clk <= 1'b0;
    upload_data <= ~word[0];
    // strobe after all 16 bits, serial clock idle meanwhile
    repeat (2) @(posedge clk);
    load_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : upload

  // frame start held 3 cycles, row clock at least 1
  task automatic pulse(input logic is_frame);
    @(posedge clk);
    if (is_frame)
      frame_start <= 1'b1;
    else
      row_clock <= 1'b1;
    repeat (3) @(posedge clk);
    frame_start <= 1'b0;
    row_clock <= 1'b0;
  endtask : pulse
endmodule : isr_ctrl_model
`default_nettype wire

// [isr_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) \
  begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %s", $time, m); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module image_sensor_readout_ctrl_bench;
  import isr_pkg::*;
  logic clk, rst_n, ext_conv_clk, ce, analog_valid;
  logic upload_clk, upload_data, load_strobe, row_clock, frame_start;
  logic [PIX_W-1:0] conv_a_code, conv_b_code, pix_out, pix_oe;
  logic pixel_valid, end_of_line, end_of_frame;
  logic [11:0] hwin_start, vwin_start, cal_level;
  logic [1:0] test_mode;
  logic [2:0] hsub_mode, vsub_mode, amp_clk_delay, conv_clk_delay;
  logic [3:0] amp_gain;
  logic [7:0] black_coarse, black_fine;
  logic amp_unity, analog_video_a_mux, amp_b_standby, amp_standby;
  logic amp_clk_invert, conv_a_standby, conv_b_standby, conv_clk_invert;
  logic conv_gamma, conv_clk_ext_sel;
  int n_fail = 0;
  int n_compared = 0;

  isr_readout u_isr_readout (.clk(clk), .rst_n(rst_n), .ce(ce),
    .upload_clk(upload_clk), .upload_data(upload_data),
    .load_strobe(load_strobe), .row_clock(row_clock),
    .frame_start(frame_start), .conv_a_code(conv_a_code),
    .conv_b_code(conv_b_code), .ext_conv_clk(ext_conv_clk),
    .pixel_valid(pixel_valid), .end_of_line(end_of_line),
    .end_of_frame(end_of_frame), .analog_valid(analog_valid),
    .pix_out(pix_out),
    .pix_oe(pix_oe), .hwin_start(hwin_start), .vwin_start(vwin_start),
    .test_mode(test_mode), .hsub_mode(hsub_mode), .vsub_mode(vsub_mode),
    .amp_gain(amp_gain), .amp_unity(amp_unity),
    .analog_video_a_mux(analog_video_a_mux),
    .amp_b_standby(amp_b_standby), .amp_standby(amp_standby),
    .amp_clk_delay(amp_clk_delay), .amp_clk_invert(amp_clk_invert),
    .black_coarse(black_coarse), .black_fine(black_fine),
    .cal_level(cal_level), .conv_a_standby(conv_a_standby),
    .conv_b_standby(conv_b_standby), .conv_clk_delay(conv_clk_delay),
    .conv_clk_invert(conv_clk_invert), .conv_gamma(conv_gamma),
    .conv_clk_ext_sel(conv_clk_ext_sel));

  isr_ctrl_model u_isr_ctrl_model (.clk(clk), .upload_clk(upload_clk),
    .upload_data(upload_data), .load_strobe(load_strobe),
    .row_clock(row_clock), .frame_start(frame_start));

  // 25 MHz system clock, external converter clock at half rate
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
    ext_conv_clk <= (rst_n === 1'b1) ? ~ext_conv_clk : 1'b0;

  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    u_isr_ctrl_model.upload(a, d);
  endtask : wr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_amp;
    wr(ADDR_AMP, 12'h2AA);
    `CHK(amp_gain, 4'hA, "gain")
    `CHK(amp_unity, 1'b0, "unity off")
    `CHK(analog_video_a_mux, 1'b1, "mux")
    `CHK(amp_b_standby, 1'b1, "b standby")
    `CHK(amp_clk_delay, 3'h5, "amp dly")
    `CHK(amp_clk_invert, 1'b1, "amp inv")
    wr(ADDR_AMP, 12'h050);
    `CHK(amp_unity, 1'b1, "unity on")
    `CHK(amp_standby, 1'b1, "amp standby")
    `CHK(analog_video_a_mux, 1'b0, "dual")
    `CHK(amp_clk_invert, 1'b0, "amp inv off")
  endtask : t_amp

  task automatic t_conv;
    wr(ADDR_CONV, 12'h2F1);
    `CHK(conv_a_standby, 1'b1, "stby a")
    `CHK(conv_b_standby, 1'b0, "stby b")
    `CHK(conv_clk_ext_sel, 1'b1, "ext clk")
    `CHK(conv_clk_delay, 3'h3, "conv dly")
    `CHK(conv_clk_invert, 1'b0, "conv inv")
    `CHK(conv_gamma, 1'b1, "gamma")
    `CHK(pix_oe, 10'h000, "float")
    // single converter b, inverted; codes held so pipeline settles
    wr(ADDR_CONV, 12'h40C);
    repeat (20) @(posedge clk);
    #1;
    `CHK(pix_oe, 10'h3FF, "drive")
    `CHK(pix_out, ~conv_b_code, "conv b inverted")
    wr(ADDR_CONV, 12'h004);
    repeat (20) @(posedge clk);
    #1;
    `CHK(pix_out, conv_a_code, "conv a")
  endtask : t_conv

  task automatic t_cfg;
    wr(ADDR_CORE, 12'h0AD);
    `CHK(test_mode, 2'h1, "test")
    `CHK(hsub_mode, 3'h3, "hsub")
    `CHK(vsub_mode, 3'h5, "vsub")
    wr(ADDR_HWIN, 12'h0C8);
    `CHK(hwin_start, 12'h062, "hwin clamp")
    wr(ADDR_VWIN, 12'h089);
    `CHK(vwin_start, 12'h089, "vwin top")
    wr(4'hB, 12'h000);
    `CHK(hwin_start, 12'h062, "unmapped")
    wr(ADDR_BLC, 12'h0FF);
    wr(ADDR_BLF, 12'h07F);
    wr(ADDR_CAL, 12'h123);
    `CHK(black_coarse, 8'hFF, "coarse")
    `CHK(black_fine, 8'h7F, "fine")
    `CHK(cal_level, 12'h123, "cal")
    // clock enable low freezes the load path, so the strobe is lost
    ce <= 1'b0;
    wr(ADDR_CAL, 12'h456);
    `CHK(cal_level, 12'h123, "ce frozen")
    ce <= 1'b1;
  endtask : t_cfg

  // one row: start delay, valid width, eol and eof seen after the fall
  task automatic row(input logic fr, output int t0, output int w,
                     output logic eol, output logic eof);
    int n;
    u_isr_ctrl_model.pulse(fr);
    n = 0;
    eol = 1'b0;
    eof = 1'b0;
    while (pixel_valid !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300)
      begin
        n_fail++;
        end_sim();
      end
    end
    t0 = n;
    w = 0;
    while (pixel_valid === 1'b1 && w < 300)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    // next pulse comes well over 2 clocks after eol/eof
    for (int i = 0; i < 20; i++)
    begin
      eol = eol | (end_of_line === 1'b1);
      eof = eof | (end_of_frame === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask : row

  task automatic t_rows;
    int t0, t1, w;
    logic eol, eof;
    wr(ADDR_PIXCNT, 12'h005);
    wr(ADDR_LINECNT, 12'h001);
    wr(ADDR_STRDLY, 12'h000);
    row(1'b1, t0, w, eol, eof);
    `CHK(w, 6, "valid width")
    `CHK(eol, 1'b1, "eol")
    `CHK(eof, 1'b0, "early eof")
    row(1'b0, t0, w, eol, eof);
    `CHK(eof, 1'b1, "eof")
    wr(ADDR_STRDLY, 12'h055);
    row(1'b1, t1, w, eol, eof);
    `CHK(t1 - t0, 3, "valid delay")
    `CHK(eol, 1'b1, "eol delayed")
  endtask : t_rows

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    conv_a_code = 10'h155;
    conv_b_code = 10'h0F3;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(black_fine, 8'h80, "fine reset")
    `CHK(pix_oe, 10'h3FF, "oe reset")
    `CHK(hwin_start, 12'h000, "hwin reset")
    `CHK(analog_valid, 1'b0, "analog idle")
    t_cfg();
    t_amp();
    t_conv();
    t_rows();
    end_sim();
  end
endmodule : image_sensor_readout_ctrl_bench
`default_nettype wire
